//--- pmx_port_pin_control_mux.sv
/*
  Port pin control for two bidirectional ports and one input-only port,
  with an Avalon-MM register slave using waitrequest.
  Assumes pads resolve output, active-low enable and pull controls, the
  analog path to the converter is a pad-level wire, and drive strength
  settings come from registers held elsewhere.
*/
// Overview of operation
// RULE_01 - eighteen pins in three ports
// RULE_02 - ten bidirectional pins, eight input-only pins
// RULE_03 - direction bit selects driver or input path
// RULE_04 - reset leaves every pin an undriven input
// RULE_05 - input level readable in data register
// RULE_06 - open-drain bit picks open-drain or push-pull
// RULE_07 - data bit drives pin as plain output
// RULE_08 - alternate selects route peripheral output line
// RULE_09 - software matches direction to alternate function
// RULE_10 - pull select and pull enable per pin
// RULE_11 - drive strength independent of pin mode
// RULE_12 - input-only direction bit gates input path
// RULE_13 - input-only level readable when path enabled
// RULE_14 - analog input bypasses digital input path
// RULE_15 - four output sources, input feeds peripherals
// RULE_16 - per-port registers at consecutive word offsets
// RULE_17 - bit n maps pin n, two-bit source code
// RULE_18 - pin inputs synchronised before use
`timescale 1ns/100ps
module pmx_port_pin_control_mux (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,

  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,

  // first bidirectional port pads
  input wire logic [5:0] first_bidir_port_pin_in,
  output logic [5:0] first_bidir_port_pin_out,
  output logic [5:0] first_bidir_port_pin_oe_n_out,
  output logic [5:0] first_bidir_port_pull_up_out,
  output logic [5:0] first_bidir_port_pull_dn_out,

  // first bidirectional port peripheral side
  input wire logic [5:0] first_bidir_port_alt_one_in,
  input wire logic [5:0] first_bidir_port_alt_two_in,
  input wire logic [5:0] first_bidir_port_alt_three_in,
  output logic [5:0] first_bidir_port_periph_in_out,

  // second bidirectional port pads (bit 3 not bonded)
  input wire logic [4:0] second_bidir_port_pin_in,
  output logic [4:0] second_bidir_port_pin_out,
  output logic [4:0] second_bidir_port_pin_oe_n_out,
  output logic [4:0] second_bidir_port_pull_up_out,
  output logic [4:0] second_bidir_port_pull_dn_out,

  // second bidirectional port peripheral side
  input wire logic [4:0] second_bidir_port_alt_one_in,
  input wire logic [4:0] second_bidir_port_alt_two_in,
  input wire logic [4:0] second_bidir_port_alt_three_in,
  output logic [4:0] second_bidir_port_periph_in_out,

  // input-only port
  input wire logic [7:0] input_only_port_pin_in,
  output logic [7:0] input_only_port_pull_up_out,
  output logic [7:0] input_only_port_pull_dn_out,
  output logic [7:0] input_only_port_periph_in_out,

  // drive strength, two bits per bidirectional pin
  input wire logic [19:0] drive_strength_control_in,
  output logic [19:0] drive_strength_control_out
);

  // configuration registers, one block per port
  pmx_pkg::pmx_port_cfg_type cfg_reg [pmx_pkg::PMX_PORTS];
  pmx_pkg::pmx_port_cfg_type cfg_next [pmx_pkg::PMX_PORTS];

  // bus slave state
  logic wait_reg;
  logic wait_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // pad side state
  logic [7:0] pull_up_reg;
  logic [7:0] pull_dn_reg;
  logic [23:0] periph_reg;
  logic [23:0] periph_next;
  logic [19:0] drive_reg;

  // synchronised pin levels, 8 bits per port
  wire logic [23:0] pins_raw;
  wire logic [23:0] pins_stable;
  wire logic [7:0] stable_port [pmx_pkg::PMX_PORTS];
  wire logic [7:0] input_seen [pmx_pkg::PMX_PORTS];
  wire logic [7:0] data_view [pmx_pkg::PMX_PORTS];

  // address decode
  wire logic [1:0] sel_port;
  wire logic [2:0] sel_idx;
  wire logic addr_hit;
  wire logic bus_req;
  wire logic bus_take;
  wire logic wr_fire;
  wire logic [7:0] wr_byte;
  logic [7:0] rd_byte;

  // pad drive results of both bidirectional ports
  pmx_pkg::pmx_pad_drive_type pad0;
  pmx_pkg::pmx_pad_drive_type pad1;

  // pad inputs packed per port; unbonded bits held low
  assign pins_raw = {input_only_port_pin_in,
                     3'h0, second_bidir_port_pin_in,
                     2'h0, first_bidir_port_pin_in}; // see RULE_01 see RULE_02

  // every pad level is synchronised before any use
  pmx_pin_sync #(
    .WIDTH(24)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(pins_raw),
    .stable_out(pins_stable)
  ); // see RULE_18

  generate
    for (genvar p = 0; p < 3; p++) begin : g_port_view
      assign stable_port[p] = pins_stable[8*p +: 8] &
                              pmx_pkg::pmx_port_mask(2'(p));
      // input path closed while the pin drives, or while disabled on
      // the input-only port
      assign input_seen[p] = stable_port[p] & ~cfg_reg[p].dir; // see RULE_03 see RULE_12
      // output mode shows the latch; input mode shows the pin level
      assign data_view[p] = (cfg_reg[p].data & cfg_reg[p].dir) |
                            input_seen[p]; // see RULE_05 see RULE_13
    end
  endgenerate

  // analog channels leave the pad before the Schmitt stage; nothing here
  // gates them, so the input-only direction bit never blocks the ADC
  assign periph_next = {input_seen[2], input_seen[1],
                        input_seen[0]}; // see RULE_14 see RULE_15

  // word-aligned decode: [6:5] port, [4:2] register, [1:0] must be zero
  assign sel_port = avs_address_in[pmx_pkg::PMX_PORT_LSB +: 2];
  assign sel_idx = avs_address_in[pmx_pkg::PMX_IDX_LSB +: 3];
  assign addr_hit = (avs_address_in[7] == 1'b0) &&
                    (sel_port != 2'h3) &&
                    (avs_address_in[1:0] == 2'h0) &&
                    (sel_idx <= pmx_pkg::PMX_IDX_ALT_HI); // see RULE_16

  // one-cycle low waitrequest per request; write lands on that edge
  assign bus_req = avs_read_in | avs_write_in;
  assign bus_take = bus_req & wait_reg;
  assign wait_next = ~bus_take;
  assign wr_fire = avs_write_in & ~wait_reg & addr_hit & avs_byteenable_in[0];
  assign wr_byte = avs_writedata_in[7:0] & pmx_pkg::pmx_port_mask(sel_port);

  // input-only port holds just data view, direction and pulls
  function automatic logic pmx_writable(input logic [1:0] port,
                                        input logic [2:0] idx);
    logic ok;
    ok = 1'b1;
    if (port == 2'h2) begin
      ok = (idx == pmx_pkg::PMX_IDX_DIR) ||
           (idx == pmx_pkg::PMX_IDX_PULL_SEL) ||
           (idx == pmx_pkg::PMX_IDX_PULL_EN);
    end
    return ok;
  endfunction

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      cfg_next[p] = cfg_reg[p];
    end
    if (wr_fire && pmx_writable(sel_port, sel_idx)) begin
      unique case (sel_idx)
        pmx_pkg::PMX_IDX_DATA: cfg_next[sel_port].data = wr_byte; // see RULE_07
        pmx_pkg::PMX_IDX_DIR: cfg_next[sel_port].dir = wr_byte; // see RULE_03
        pmx_pkg::PMX_IDX_OD: cfg_next[sel_port].od = wr_byte; // see RULE_06
        pmx_pkg::PMX_IDX_PULL_SEL: cfg_next[sel_port].pull_sel = wr_byte;
        pmx_pkg::PMX_IDX_PULL_EN: cfg_next[sel_port].pull_en = wr_byte;
        pmx_pkg::PMX_IDX_ALT_LO: cfg_next[sel_port].alt_lo = wr_byte; // see RULE_08
        pmx_pkg::PMX_IDX_ALT_HI: cfg_next[sel_port].alt_hi = wr_byte; // see RULE_08
        default: cfg_next[sel_port].data = cfg_reg[sel_port].data;
      endcase
    end
  end

  // read mux; unmapped offsets and absent fields read zero
  always_comb begin
    rd_byte = pmx_pkg::PMX_RST_FIELD;
    if (addr_hit) begin
      unique case (sel_idx)
        pmx_pkg::PMX_IDX_DATA: rd_byte = data_view[sel_port]; // see RULE_05
        pmx_pkg::PMX_IDX_DIR: rd_byte = cfg_reg[sel_port].dir;
        pmx_pkg::PMX_IDX_OD: rd_byte = cfg_reg[sel_port].od;
        pmx_pkg::PMX_IDX_PULL_SEL: rd_byte = cfg_reg[sel_port].pull_sel;
        pmx_pkg::PMX_IDX_PULL_EN: rd_byte = cfg_reg[sel_port].pull_en;
        pmx_pkg::PMX_IDX_ALT_LO: rd_byte = cfg_reg[sel_port].alt_lo;
        pmx_pkg::PMX_IDX_ALT_HI: rd_byte = cfg_reg[sel_port].alt_hi;
        default: rd_byte = pmx_pkg::PMX_RST_FIELD;
      endcase
    end
  end

  // readdata only moves when a read is taken, so it stands at the ack edge
  assign rdata_next = (bus_take && avs_read_in) ? {24'h00_0000, rd_byte} :
                      rdata_reg;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wait_reg <= 1'b1;
      rdata_reg <= pmx_pkg::PMX_RST_RDATA;
    end else begin
      wait_reg <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int p = 0; p < 3; p++) begin
        cfg_reg[p] <= pmx_pkg::PMX_CFG_RST; // see RULE_04
      end
    end else begin
      for (int p = 0; p < 3; p++) begin
        cfg_reg[p] <= cfg_next[p];
      end
    end
  end

  // direction is never forced by the alternate selection; software sets
  // it to suit the peripheral
  pmx_pad_drive u_pad_first (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .cfg_in(cfg_reg[0]),
    .alt_one_in({2'h0, first_bidir_port_alt_one_in}),
    .alt_two_in({2'h0, first_bidir_port_alt_two_in}),
    .alt_three_in({2'h0, first_bidir_port_alt_three_in}),
    .pad_out(pad0)
  ); // see RULE_09 see RULE_15

  pmx_pad_drive u_pad_second (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .cfg_in(cfg_reg[1]),
    .alt_one_in({3'h0, second_bidir_port_alt_one_in}),
    .alt_two_in({3'h0, second_bidir_port_alt_two_in}),
    .alt_three_in({3'h0, second_bidir_port_alt_three_in}),
    .pad_out(pad1)
  );

  // input-only pulls, peripheral inputs and drive strength, registered
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pull_up_reg <= pmx_pkg::PMX_RST_FIELD;
      pull_dn_reg <= pmx_pkg::PMX_RST_FIELD;
      periph_reg <= 24'h00_0000;
      drive_reg <= pmx_pkg::PMX_RST_DRIVE;
    end else begin
      pull_up_reg <= cfg_reg[2].pull_en & cfg_reg[2].pull_sel; // see RULE_10
      pull_dn_reg <= cfg_reg[2].pull_en & ~cfg_reg[2].pull_sel; // see RULE_10
      periph_reg <= periph_next;
      // strength passes unchanged in every pin mode
      drive_reg <= drive_strength_control_in; // see RULE_11
    end
  end

  assign avs_waitrequest_out = wait_reg;
  assign avs_readdata_out = rdata_reg;

  assign first_bidir_port_pin_out = pad0.value[5:0];
  assign first_bidir_port_pin_oe_n_out = pad0.oe_n[5:0];
  assign first_bidir_port_pull_up_out = pad0.pull_up[5:0];
  assign first_bidir_port_pull_dn_out = pad0.pull_dn[5:0];
  assign first_bidir_port_periph_in_out = periph_reg[5:0];

  assign second_bidir_port_pin_out = pad1.value[4:0];
  assign second_bidir_port_pin_oe_n_out = pad1.oe_n[4:0];
  assign second_bidir_port_pull_up_out = pad1.pull_up[4:0];
  assign second_bidir_port_pull_dn_out = pad1.pull_dn[4:0];
  assign second_bidir_port_periph_in_out = periph_reg[12:8];

  assign input_only_port_pull_up_out = pull_up_reg;
  assign input_only_port_pull_dn_out = pull_dn_reg;
  assign input_only_port_periph_in_out = periph_reg[23:16];

  assign drive_strength_control_out = drive_reg;

endmodule

//--- pmx_pkg.sv
/*
  Shared constants and types for the port pin control block: register
  offsets, reset values, implemented-pin masks, carrier structs and the
  output source selection function.
  Assumes a single 125 MHz system clock domain for all users.
*/
package pmx_pkg;

  localparam int unsigned PMX_PORTS = 3;

  // register word indices within one port block; PMX_OFS_DATA and PMX_OFS_ALT_HI are byte addresses
  localparam logic [2:0] PMX_IDX_DATA = 3'h0;
  localparam logic [2:0] PMX_IDX_DIR = 3'h1;
  localparam logic [2:0] PMX_IDX_OD = 3'h2;
  localparam logic [2:0] PMX_IDX_PULL_SEL = 3'h3;
  localparam logic [2:0] PMX_IDX_PULL_EN = 3'h4;
  localparam logic [2:0] PMX_IDX_ALT_LO = 3'h5;
  localparam logic [2:0] PMX_IDX_ALT_HI = 3'h6;
  localparam logic [7:0] PMX_OFS_DATA = 8'h00;
  localparam logic [7:0] PMX_OFS_ALT_HI = 8'h18;

  // port block bases; bits [6:5] of the address select the port
  localparam logic [7:0] PMX_BASE_PORT0 = 8'h00;
  localparam logic [7:0] PMX_BASE_PORT1 = 8'h20;
  localparam logic [7:0] PMX_BASE_PORT2 = 8'h40;
  localparam int unsigned PMX_PORT_LSB = 5;
  localparam int unsigned PMX_IDX_LSB = 2;

  // implemented pins: 6 + 4 bidirectional, 8 input only
  localparam logic [7:0] PMX_MASK_PORT0 = 8'h3F;
  localparam logic [7:0] PMX_MASK_PORT1 = 8'h17;
  localparam logic [7:0] PMX_MASK_PORT2 = 8'hFF;

  localparam logic [7:0] PMX_RST_FIELD = 8'h00;
  localparam logic [7:0] PMX_RST_OE_N = 8'hFF;
  localparam logic [31:0] PMX_RST_RDATA = 32'h0000_0000;
  localparam logic [19:0] PMX_RST_DRIVE = 20'h0_0000;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] dir;
    logic [7:0] od;
    logic [7:0] pull_sel;
    logic [7:0] pull_en;
    logic [7:0] alt_lo;
    logic [7:0] alt_hi;
  } pmx_port_cfg_type;

  localparam pmx_port_cfg_type PMX_CFG_RST = {7{PMX_RST_FIELD}};

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] oe_n;
    logic [7:0] pull_up;
    logic [7:0] pull_dn;
  } pmx_pad_drive_type;

  localparam pmx_pad_drive_type PMX_PAD_RST =
    {PMX_RST_FIELD, PMX_RST_OE_N, PMX_RST_FIELD, PMX_RST_FIELD};

  // {alt_hi, alt_lo}: 00 data bit, 01/10/11 peripheral outputs one..three
  function automatic logic pmx_alt_pick(input logic [1:0] sel,
                                        input logic d, input logic a1,
                                        input logic a2, input logic a3);
    logic r;
    unique case (sel)
      2'h0: r = d;
      2'h1: r = a1;
      2'h2: r = a2;
      2'h3: r = a3;
    endcase
    return r;
  endfunction

  function automatic logic [7:0] pmx_port_mask(input logic [1:0] port);
    logic [7:0] m;
    unique case (port)
      2'h0: m = PMX_MASK_PORT0;
      2'h1: m = PMX_MASK_PORT1;
      2'h2: m = PMX_MASK_PORT2;
      default: m = PMX_RST_FIELD;
    endcase
    return m;
  endfunction

endpackage

//--- pmx_pin_sync.sv
/*
  Three-flop input synchroniser with agreement filter for pad inputs.
  Assumes inputs are asynchronous to ref_clk_in; output changes only once
  the second and third stages agree.
*/
`timescale 1ns/100ps
module pmx_pin_sync #(
  parameter int unsigned WIDTH = 24
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // pad side
  input wire logic [WIDTH-1:0] async_in,
  // clock domain side
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] stable_next;

  // per bit: take the new level only where stages two and three agree
  assign stable_next = (stage2_reg & ~(stage2_reg ^ stage3_reg)) |
                       (stable_out & (stage2_reg ^ stage3_reg));

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      stable_out <= '0;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      stable_out <= stable_next;
    end
  end

endmodule

//--- pmx_pad_drive.sv
/*
  Registered pad drive for one bidirectional port: output source mux,
  push-pull or open-drain enable, pull device selection.
  Assumes the configuration comes from registers in the same clock domain.
*/
`timescale 1ns/100ps
module pmx_pad_drive (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // configuration and peripheral output lines
  input wire pmx_pkg::pmx_port_cfg_type cfg_in,
  input wire logic [7:0] alt_one_in,
  input wire logic [7:0] alt_two_in,
  input wire logic [7:0] alt_three_in,
  // pad controls
  output pmx_pkg::pmx_pad_drive_type pad_out
);

  logic [7:0] src_value;
  pmx_pkg::pmx_pad_drive_type pad_next;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // see RULE_07 see RULE_08 see RULE_17
      src_value[i] = pmx_pkg::pmx_alt_pick({cfg_in.alt_hi[i],
                                            cfg_in.alt_lo[i]},
                                           cfg_in.data[i], alt_one_in[i],
                                           alt_two_in[i], alt_three_in[i]);
    end
  end

  // open drain only ever pulls low; high is left to the pull-up
  assign pad_next.value = src_value & ~cfg_in.od; // see RULE_06
  assign pad_next.oe_n = ~(cfg_in.dir & (~cfg_in.od | ~src_value)); // see RULE_03
  assign pad_next.pull_up = cfg_in.pull_en & cfg_in.pull_sel; // see RULE_10
  assign pad_next.pull_dn = cfg_in.pull_en & ~cfg_in.pull_sel; // see RULE_10

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pad_out <= pmx_pkg::PMX_PAD_RST; // see RULE_04
    end else begin
      pad_out <= pad_next;
    end
  end

endmodule

//--- pmx_chk_asserts.sv
/*
  Checker for the port pin control block: bus handshake, read data,
  pad drive, pull and drive strength relations.
  Assumes it is bound to the top module with ports matched by name.
*/
`timescale 1ns/100ps
module pmx_chk (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  // register bus
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // pads
  input wire logic [5:0] first_bidir_port_pin_oe_n_out,
  input wire logic [4:0] second_bidir_port_pin_oe_n_out,
  input wire logic [5:0] first_bidir_port_periph_in_out,
  input wire logic [5:0] first_bidir_port_pull_up_out,
  input wire logic [5:0] first_bidir_port_pull_dn_out,
  input wire logic [7:0] input_only_port_pull_up_out,
  input wire logic [7:0] input_only_port_pull_dn_out,
  // drive strength
  input wire logic [19:0] drive_strength_control_in,
  input wire logic [19:0] drive_strength_control_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  // pins may only start driving once software has written something
  logic wrote_reg;
  wire [5:0] drv0 = ~first_bidir_port_pin_oe_n_out;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) wrote_reg <= 1'b0;
    else if (avs_write_in) wrote_reg <= 1'b1;
  end

  sequence req_taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence ack_one;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  req_ack_a: assert property (req_taken |=> ack_one)
    else $error("request not answered by a one cycle acknowledge");
  ack_cause_a: assert property ($fell(avs_waitrequest_out) |->
    $past(avs_read_in || avs_write_in))
    else $error("acknowledge without a request");
  rd_hold_a: assert property (!(avs_read_in && avs_waitrequest_out)
    |=> $stable(avs_readdata_out))
    else $error("read data changed without a read");
  rd_upper_a: assert property (avs_readdata_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  drive_copy_a: assert property ($past(nrst_in) |->
    drive_strength_control_out == $past(drive_strength_control_in))
    else $error("drive strength not passed through in one cycle");
  pull_excl_a: assert property ((first_bidir_port_pull_up_out &
    first_bidir_port_pull_dn_out) == 6'h00)
    else $error("pull-up and pull-down on together");
  in_pull_a: assert property ((input_only_port_pull_up_out &
    input_only_port_pull_dn_out) == 8'h00)
    else $error("input-only pull-up and pull-down on together");
  io_excl_a: assert property ((drv0 &
    first_bidir_port_periph_in_out) == 6'h00)
    else $error("pin driving and input path open at once");
  undriven_a: assert property (!wrote_reg |-> &{
    first_bidir_port_pin_oe_n_out, second_bidir_port_pin_oe_n_out})
    else $error("pin driven before any configuration");
endmodule

//--- pmx_board.sv
/*
  Board side of the pads: resolves device drive, external drivers and
  weak pulls into clean pin levels.
  Assumes one clock, used only to make floating pins wander.
*/
`timescale 1ns/100ps
module pmx_board #(
  parameter int unsigned W = 24
) (
  // clock
  input wire logic ref_clk_in,
  // device pad controls
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] oe_n_in,
  input wire logic [W-1:0] pull_up_in,
  input wire logic [W-1:0] pull_dn_in,
  // external drivers
  input wire logic [W-1:0] ext_val_in,
  input wire logic [W-1:0] ext_en_in,
  // resolved levels
  output logic [W-1:0] level_out
);
  // a floating pin toggles, so nothing may rely on its value
  logic [W-1:0] float_reg = '0;

  always @(posedge ref_clk_in) float_reg <= ~float_reg;

  // levels are clean 0 or 1, as after a schmitt stage
  // a released open-drain pin falls to pull or board
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n_in[i]) level_out[i] = pin_in[i];
      else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
      else if (pull_up_in[i]) level_out[i] = 1'b1;
      else if (pull_dn_in[i]) level_out[i] = 1'b0;
      else level_out[i] = float_reg[i];
    end
  end
endmodule

//--- pmx_tb.sv
/*
  Self-checking bench for the port pin control block: register map,
  output sources, open drain, pulls, input paths and reset.
  Assumes the board model and checker are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  logic ref_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic [7:0] avs_address_in = 8'h00;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h00000000;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [5:0] first_bidir_port_pin_out, first_bidir_port_pin_oe_n_out;
  logic [5:0] first_bidir_port_pull_up_out, first_bidir_port_pull_dn_out;
  logic [5:0] first_bidir_port_periph_in_out;
  logic [4:0] second_bidir_port_pin_out, second_bidir_port_pin_oe_n_out;
  logic [4:0] second_bidir_port_pull_up_out, second_bidir_port_pull_dn_out;
  logic [4:0] second_bidir_port_periph_in_out;
  logic [7:0] input_only_port_pull_up_out, input_only_port_pull_dn_out;
  logic [7:0] input_only_port_periph_in_out;
  logic [19:0] drive_strength_control_in = 20'h00000;
  logic [19:0] drive_strength_control_out;
  logic [15:0] peripheral_output_one = 16'h0000, peripheral_output_two = 16'h0000, peripheral_output_three = 16'h0000;
  logic [23:0] ext_val = 24'h000000, ext_en = 24'h000000, lvl;
  logic [15:0] seed = 16'h776D;
  int miscompares = 0;
  int comparisons = 0;
  wire [5:0] first_bidir_port_pin_in = lvl[5:0];
  wire [4:0] second_bidir_port_pin_in = lvl[12:8];
  wire [7:0] input_only_port_pin_in = lvl[23:16];
  wire [5:0] first_bidir_port_alt_one_in = peripheral_output_one[5:0];
  wire [5:0] first_bidir_port_alt_two_in = peripheral_output_two[5:0];
  wire [5:0] first_bidir_port_alt_three_in = peripheral_output_three[5:0];
  wire [4:0] second_bidir_port_alt_one_in = peripheral_output_one[12:8];
  wire [4:0] second_bidir_port_alt_two_in = peripheral_output_two[12:8];
  wire [4:0] second_bidir_port_alt_three_in = peripheral_output_three[12:8];
  // one byte lane per port, unbonded bits padded as undriven
  wire [15:0] pout = {3'h0, second_bidir_port_pin_out, 2'h0,
    first_bidir_port_pin_out};
  wire [15:0] poe = {3'h7, second_bidir_port_pin_oe_n_out, 2'h3,
    first_bidir_port_pin_oe_n_out};
  wire [23:0] pup = {input_only_port_pull_up_out, 3'h0,
    second_bidir_port_pull_up_out, 2'h0, first_bidir_port_pull_up_out};
  wire [23:0] pdn = {input_only_port_pull_dn_out, 3'h0,
    second_bidir_port_pull_dn_out, 2'h0, first_bidir_port_pull_dn_out};
  wire [23:0] pper = {input_only_port_periph_in_out, 3'h0,
    second_bidir_port_periph_in_out, 2'h0, first_bidir_port_periph_in_out};

  pmx_port_pin_control_mux i_dut (.*);

  pmx_board #(.W(24)) i_board (
    .ref_clk_in(ref_clk_in),
    .pin_in({8'h00, pout}),
    .oe_n_in({8'hFF, poe}),
    .pull_up_in(pup),
    .pull_dn_in(pdn),
    .ext_val_in(ext_val),
    .ext_en_in(ext_en),
    .level_out(lvl)
  );

  always #4 ref_clk_in = ~ref_clk_in;

  function logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction

  function automatic logic [7:0] msk(input int p);
    return p == 0 ? 8'h3F : p == 1 ? 8'h17 : 8'hFF;
  endfunction

  function automatic logic [7:0] src(input logic [7:0] lo, hi, d, x, y, z);
    for (int i = 0; i < 8; i++)
      src[i] = hi[i] ? (lo[i] ? z[i] : y[i]) : (lo[i] ? x[i] : d[i]);
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] q);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= !w;
    do begin
      @(posedge ref_clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask

  task automatic wr(input int p, r, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, 8'(p * 32 + r * 4), {24'h000000, d}, 4'hF, q);
  endtask

  task automatic rd_chk(input int p, r, input logic [7:0] e, mk);
    logic [31:0] q;
    bus(1'b0, 8'(p * 32 + r * 4), 32'h00000000, 4'hF, q);
    `CHK(q & {24'h000000, mk}, {24'h000000, e & mk})
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    logic [7:0] v, d, dir, od, lo, hi, s, m, old;
    logic [31:0] q;
    int p;
    repeat (4) @(posedge ref_clk_in);
    nrst_in <= 1'b1;
    @(posedge ref_clk_in);
    `CHK(poe, 16'hFFFF)
    `CHK(pup | pdn, 24'h000000)
    for (p = 0; p < 3; p++)
      for (int r = 1; r < 7; r++) begin
        v = rnd();
        wr(p, r, v);
        rd_chk(p, r, (p == 2 && r != 1 && r != 3 && r != 4) ? 8'h00 :
          v & msk(p), 8'hFF);
      end
    rd_chk(3, 0, 8'h00, 8'hFF);
    rd_chk(0, 7, 8'h00, 8'hFF);
    wr(0, 1, 8'h00);
    bus(1'b1, 8'h04, 32'h000000FF, 4'hE, q);
    rd_chk(0, 1, 8'h00, 8'hFF);
    // every source code on both ports, then random codes and open drain
    for (int k = 0; k < 16; k++) begin
      p = k % 2;
      m = msk(p);
      d = rnd();
      dir = rnd();
      od = (k >= 12) ? rnd() : 8'h00;
      lo = (k < 8) ? {8{k[1]}} : rnd();
      hi = (k < 8) ? {8{k[2]}} : rnd();
      peripheral_output_one <= {rnd(), rnd()};
      peripheral_output_two <= {rnd(), rnd()};
      peripheral_output_three <= {rnd(), rnd()};
      wr(p, 0, d);
      wr(p, 2, od);
      wr(p, 5, lo);
      wr(p, 6, hi);
      wr(p, 1, dir);
      repeat (3) @(posedge ref_clk_in);
      s = src(lo, hi, d, peripheral_output_one[p*8+:8], peripheral_output_two[p*8+:8], peripheral_output_three[p*8+:8]);
      `CHK(pout[p*8+:8] & dir & m, s & ~od & dir & m)
      `CHK(poe[p*8+:8] & m, ~(dir & ~(od & s)) & m)
      `CHK(pper[p*8+:8] & dir & m, 8'h00)
      rd_chk(p, 0, d, dir & m);
    end
    for (int k = 0; k < 6; k++) begin
      p = k % 3;
      m = msk(p);
      dir = (p == 2) ? rnd() : 8'h00;
      wr(p, 1, dir);
      repeat (8) @(posedge ref_clk_in);
      old = pper[p*8+:8];
      ext_val <= {rnd(), rnd(), rnd()};
      ext_en <= 24'hFFFFFF;
      repeat (2) @(posedge ref_clk_in);
      `CHK(pper[p*8+:8], old)
      repeat (6) @(posedge ref_clk_in);
      v = ext_val[p*8+:8];
      rd_chk(p, 0, v, ~dir & m);
      `CHK(pper[p*8+:8] & m, v & ~dir & m)
    end
    for (p = 0; p < 3; p++) begin
      s = rnd();
      v = rnd();
      m = msk(p);
      wr(p, 3, s);
      wr(p, 4, v);
      repeat (2) @(posedge ref_clk_in);
      `CHK(pup[p*8+:8] & m, s & v & m)
      `CHK(pdn[p*8+:8] & m, ~s & v & m)
    end
    drive_strength_control_in <= 20'({rnd(), rnd(), rnd()});
    repeat (2) @(posedge ref_clk_in);
    `CHK(drive_strength_control_out, drive_strength_control_in)
    nrst_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(poe, 16'hFFFF)
    nrst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    miscompares++;
    end_of_test();
  end
endmodule

bind pmx_port_pin_control_mux pmx_chk i_chk (.*);
